// ### include/ssm_pkg.sv
// Shared constants and types for the synchronous serial master port
// Assumes a single 100 MHz core clock and plain-port configuration
package ssm_pkg;
	// ----------------------------------------
	// Sizes and thresholds
	// ----------------------------------------
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int CTRL_W = 8;
	localparam int MIN_BITS = 4;
	localparam logic [3:0] WATERMARK = 4'h4;
	localparam logic [3:0] DSS_MIN = 4'h3;
	localparam logic [7:0] RXTO_CYCLES = 8'h40;
	localparam logic [15:0] DIV_RST = 16'h0000;
	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [1:0] {
		FMT_SPI = 2'b00,
		FMT_DSP = 2'b01,
		FMT_CTRL = 2'b10
	} ssm_fmt_t;
	typedef struct packed {
		logic tx;
		logic rx;
		logic ovr;
		logic rxto;
	} ssm_irq_t;
	typedef struct packed {
		logic enable;
		ssm_fmt_t fmt;
		logic cpol;
		logic cpha;
		logic loopback;
		logic [3:0] dss;
		logic [2:0] presc_sel;
		logic [7:0] scr;
		ssm_irq_t int_mask;
	} ssm_cfg_t;
endpackage

// ### src/ssm_fifo.sv
// First-in first-out store with registered full and empty flags
// Assumes writer and reader share the core clock
module ssm_fifo
	import ssm_pkg::*;
#(
	parameter int W = 16,
	parameter int DEPTH = 8,
	parameter int AW = 3
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Fill side
	input wire logic wr_valid_in,
	input wire logic [W-1:0] wr_data_in,
	output logic wr_ready_out,
	// Drain side
	output logic rd_valid_out,
	output logic [W-1:0] rd_data_out,
	input wire logic rd_ready_in,
	// Fill level
	output logic [AW:0] level_out
);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wp_q, rp_q;
	logic [AW:0] lvl_q, lvl_d;
	logic full_q, empty_q, wr_en, rd_en;

	assign wr_en = wr_valid_in && !full_q;
	assign rd_en = rd_ready_in && !empty_q;
	assign lvl_d = lvl_q + (AW+1)'(wr_en) - (AW+1)'(rd_en);
	assign wr_ready_out = !full_q;
	assign rd_valid_out = !empty_q;
	assign rd_data_out = mem_q[rp_q];
	assign level_out = lvl_q;

	always_ff @(posedge clk_in) begin
		if (wr_en) begin
			mem_q[wp_q] <= wr_data_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wp_q <= '0;
			rp_q <= '0;
			lvl_q <= '0;
			full_q <= 1'b0;
			empty_q <= 1'b1;
		end else begin
			if (wr_en) wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
			if (rd_en) rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
			lvl_q <= lvl_d;
			full_q <= (lvl_d == (AW+1)'(DEPTH));
			empty_q <= (lvl_d == '0);
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	fifo_level_a: assert property (wr_en && !rd_en |=> lvl_q == $past(lvl_q) + 1'b1)
		else $error("fifo level did not rise");
	fifo_empty_a: assert property (rd_en && !wr_en && lvl_q == 1 |=> !rd_valid_out) else $error("fifo empty late");
endmodule

// ### src/ssm_port.sv
// Master-only synchronous serial port: FIFOs, bit-rate divider, framing
// Assumes configuration is held stable by software while busy_out is high
//
// Notes on behaviour
// - Port is link master only: drives clock and framing in three formats.
// - Received bits are shifted into a word and pushed to receive FIFO.
// - Transmit and receive FIFOs each hold eight 16-bit words.
// - Software writes words to transmit FIFO; they are sent in order.
// - Each word is wrapped in the framing of the selected format.
// - Frame size programmable 4 to 16 bits; only low bits transferred.
// - Frames go out and come in most significant bit first.
// - Four interrupt requests, each gated by its own enable bit.
// - Combined interrupt is OR of the four enabled requests.
// - FIFO levels crossing watermark raise service requests.
// - Serial bit rate is programmable by division of port clock.
// - SPI format: selectable clock polarity and phase, full duplex.
// - DSP frame format: full duplex with one-bit frame pulse.
// - Control-word format: 8-bit control out, then slave data in only.
// - Port clock is core clock divided by 1 to 128 in powers of two.
module ssm_port
	import ssm_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_in,
	// Configuration and flag clears
	input wire ssm_cfg_t cfg_in,
	input wire logic ovr_clr_in,
	input wire logic rxto_clr_in,
	// Transmit word stream
	input wire logic tx_valid_in,
	input wire logic [WORD_W-1:0] tx_data_in,
	output logic tx_ready_out,
	// Receive word stream
	output logic rx_valid_out,
	output logic [WORD_W-1:0] rx_data_out,
	input wire logic rx_ready_in,
	// Serial link
	output logic sclk_out,
	output logic mosi_out,
	input wire logic miso_in,
	output logic ss_n_out,
	output logic frame_out,
	// Status and interrupts
	output logic busy_out,
	output ssm_irq_t irq_out,
	output logic irq_any_out
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRE = 2'b01,
		ST_BITS = 2'b10,
		ST_POST = 2'b11
	} ssm_state_t;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function automatic logic [4:0] bits_of(input logic [3:0] dss);
		return (dss < DSS_MIN) ? 5'(MIN_BITS) : {1'b0, dss} + 5'h1;
	endfunction
	function automatic logic sclk_a(input ssm_cfg_t c);
		case (c.fmt)
			FMT_SPI: return c.cpha ? !c.cpol : c.cpol;
			FMT_DSP: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	function automatic logic sclk_idle(input ssm_cfg_t c);
		return (c.fmt == FMT_SPI) ? c.cpol : 1'b0;
	endfunction
	function automatic logic [15:0] half_len(input ssm_cfg_t c);
		return 16'(({8'h00, c.scr} + 16'h0001) << c.presc_sel);
	endfunction

	ssm_state_t state_q;
	ssm_cfg_t cfg_q;
	logic half_q, tick, sclk_q, mosi_q, ss_n_q, frame_q, miso_s1_q, miso_s2_q, rx_bit;
	logic [15:0] div_q, tx_sh_q, rx_sh_q;
	logic [4:0] left_q, nbits;
	logic txf_valid, txf_pop, rxf_wready, rxf_wvalid_q, ovr_q, rxto_q;
	logic [15:0] txf_data, rxf_wdata_q;
	logic [3:0] tx_lvl, rx_lvl;
	logic [7:0] to_cnt_q;
	ssm_irq_t raw, irq_q;
	logic irq_any_q;

	// ----------------------------------------
	// FIFOs
	// ----------------------------------------
	assign txf_pop = txf_valid && cfg_in.enable && state_q == ST_IDLE;
	ssm_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH), .AW(3)) tx_fifo (
		.clk_in(core_clk_in), .rst_in(rst_in),
		.wr_valid_in(tx_valid_in), .wr_data_in(tx_data_in), .wr_ready_out(tx_ready_out),
		.rd_valid_out(txf_valid), .rd_data_out(txf_data), .rd_ready_in(txf_pop),
		.level_out(tx_lvl)
	);
	ssm_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH), .AW(3)) rx_fifo (
		.clk_in(core_clk_in), .rst_in(rst_in),
		.wr_valid_in(rxf_wvalid_q), .wr_data_in(rxf_wdata_q), .wr_ready_out(rxf_wready),
		.rd_valid_out(rx_valid_out), .rd_data_out(rx_data_out), .rd_ready_in(rx_ready_in),
		.level_out(rx_lvl)
	);

	// ----------------------------------------
	// Receive pin synchroniser and loopback
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			miso_s1_q <= 1'b0;
			miso_s2_q <= 1'b0;
		end else begin
			miso_s1_q <= miso_in;
			miso_s2_q <= miso_s1_q;
		end
	end
	assign rx_bit = cfg_q.loopback ? mosi_q : miso_s2_q;

	// ----------------------------------------
	// Half-bit tick divider
	// ----------------------------------------
	assign tick = (div_q == half_len(cfg_q) - 16'h0001);
	always_ff @(posedge core_clk_in) begin
		if (rst_in || state_q == ST_IDLE || tick) begin
			div_q <= DIV_RST;
		end else begin
			div_q <= div_q + 16'h0001;
		end
	end

	// ----------------------------------------
	// Frame sequencer
	// ----------------------------------------
	assign nbits = bits_of(cfg_in.dss);
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			cfg_q <= '0;
			half_q <= 1'b0;
			left_q <= '0;
			tx_sh_q <= '0;
			rx_sh_q <= '0;
			sclk_q <= 1'b0;
			mosi_q <= 1'b0;
			ss_n_q <= 1'b1;
			frame_q <= 1'b0;
			rxf_wvalid_q <= 1'b0;
			rxf_wdata_q <= '0;
		end else begin
			rxf_wvalid_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					sclk_q <= sclk_idle(cfg_in);
					if (txf_pop) begin
						state_q <= ST_PRE;
						cfg_q <= cfg_in;
						half_q <= 1'b0;
						if (cfg_in.fmt == FMT_CTRL) begin
							tx_sh_q <= {txf_data[CTRL_W-1:0], 8'h00};
							left_q <= nbits + 5'(CTRL_W);
						end else begin
							tx_sh_q <= 16'(txf_data << (5'd16 - nbits));
							left_q <= nbits;
						end
						ss_n_q <= (cfg_in.fmt == FMT_DSP);
						frame_q <= (cfg_in.fmt == FMT_DSP);
						if (cfg_in.fmt == FMT_DSP) sclk_q <= 1'b1;
					end
				end
				ST_PRE: begin
					if (tick) begin
						half_q <= !half_q;
						if (!half_q) begin
							if (cfg_q.fmt == FMT_DSP) sclk_q <= 1'b0;
						end else begin
							state_q <= ST_BITS;
							half_q <= 1'b0;
							sclk_q <= sclk_a(cfg_q);
							mosi_q <= tx_sh_q[15];
							tx_sh_q <= {tx_sh_q[14:0], 1'b0};
							frame_q <= 1'b0;
						end
					end
				end
				ST_BITS: begin
					if (tick) begin
						half_q <= !half_q;
						if (!half_q) begin
							sclk_q <= !sclk_a(cfg_q);
							rx_sh_q <= {rx_sh_q[14:0], rx_bit};
						end else if (left_q == 5'h01) begin
							state_q <= ST_POST;
							sclk_q <= sclk_idle(cfg_q);
							ss_n_q <= 1'b1;
							rxf_wvalid_q <= 1'b1;
							rxf_wdata_q <= rx_sh_q & (16'hFFFF >> (5'd16 - bits_of(cfg_q.dss)));
						end else begin
							left_q <= left_q - 5'h01;
							sclk_q <= sclk_a(cfg_q);
							mosi_q <= tx_sh_q[15];
							tx_sh_q <= {tx_sh_q[14:0], 1'b0};
						end
					end
				end
				ST_POST: begin
					mosi_q <= 1'b0;
					if (tick) state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Interrupt requests
	// ----------------------------------------
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			ovr_q <= 1'b0;
		end else if (rxf_wvalid_q && !rxf_wready) begin
			ovr_q <= 1'b1;
		end else if (ovr_clr_in) begin
			ovr_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in || !rx_valid_out || rx_ready_in) begin
			to_cnt_q <= '0;
		end else if (to_cnt_q != RXTO_CYCLES) begin
			to_cnt_q <= to_cnt_q + 8'h01;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			rxto_q <= 1'b0;
		end else if (to_cnt_q == RXTO_CYCLES - 8'h01) begin
			rxto_q <= 1'b1;
		end else if (rxto_clr_in || rx_ready_in) begin
			rxto_q <= 1'b0;
		end
	end

	assign raw = '{tx: tx_lvl <= WATERMARK, rx: rx_lvl >= WATERMARK, ovr: ovr_q, rxto: rxto_q};
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			irq_q <= '0;
			irq_any_q <= 1'b0;
		end else begin
			irq_q <= raw & cfg_in.int_mask;
			irq_any_q <= |(raw & cfg_in.int_mask);
		end
	end

	assign sclk_out = sclk_q;
	assign mosi_out = mosi_q;
	assign ss_n_out = ss_n_q;
	assign frame_out = frame_q;
	assign busy_out = (state_q != ST_IDLE);
	assign irq_out = irq_q;
	assign irq_any_out = irq_any_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	ss_idle_a: assert property (state_q == ST_IDLE |-> ss_n_q && !frame_q)
		else $error("select active while idle");
	frame_dsp_a: assert property (frame_q |-> cfg_q.fmt == FMT_DSP && state_q == ST_PRE)
		else $error("frame pulse outside dsp preamble");
	irq_or_a: assert property (1'b1 |=> irq_any_q == |($past(raw) & $past(cfg_in.int_mask)))
		else $error("combined interrupt mismatch");
	ovr_set_a: assert property (rxf_wvalid_q && !rxf_wready |=> ovr_q)
		else $error("overrun not flagged");
	pop_start_a: assert property (txf_pop |=> state_q == ST_PRE && (!ss_n_q || frame_q))
		else $error("frame did not start after pop");
	msb_first_a: assert property (state_q == ST_PRE && tick && half_q |=> mosi_q == $past(tx_sh_q[15]))
		else $error("first bit not msb");
	ctrl_len_a: assert property (state_q == ST_PRE && cfg_q.fmt == FMT_CTRL
		|-> left_q == bits_of(cfg_q.dss) + 5'(CTRL_W))
		else $error("control frame length wrong");
	loop_rx_a: assert property (cfg_q.loopback && state_q == ST_BITS && tick && !half_q
		|=> rx_sh_q[0] == $past(mosi_q))
		else $error("loopback sample wrong");
	tick_gap_a: assert property (busy_out && tick && half_len(cfg_q) > 16'h0001 |=> !tick)
		else $error("divider tick too early");
	push_end_a: assert property (state_q == ST_BITS && tick && half_q && left_q == 5'h01
		|=> rxf_wvalid_q && state_q == ST_POST)
		else $error("received word not pushed");
	spi_done_c: cover property (cfg_q.fmt == FMT_SPI && rxf_wvalid_q);
	dsp_done_c: cover property (cfg_q.fmt == FMT_DSP && rxf_wvalid_q);
	ctrl_done_c: cover property (cfg_q.fmt == FMT_CTRL && rxf_wvalid_q);
	overrun_c: cover property (rxf_wvalid_q && !rxf_wready);
endmodule

// ### testbench/ssm_slave_model.sv
// Slave device model for clock-idle-low, sample-on-rise frames
// Assumes select low for the whole frame and a bit count from the bench
module ssm_slave_model #(
	parameter logic [15:0] REPLY = 16'hB6D1
) (
	// Serial link
	input wire logic clk_in,
	input wire logic sclk_in,
	input wire logic mosi_in,
	input wire logic ss_n_in,
	output logic miso_out,
	// Frame setup and capture
	input wire logic [4:0] bits_in,
	output logic [15:0] got_out
);
	timeunit 1ns;
	timeprecision 1ns;
	int idx = -1;
	logic junk = 1'b0;
	logic sclk_was = 1'b0;
	logic armed = 1'b0;
	// One process owns the frame state; select low starts a fresh capture
	always @(ss_n_in or sclk_in or bits_in) begin
		if (ss_n_in === 1'b1) begin
			idx = int'(bits_in) - 1;
			armed = 1'b1;
		end else if (ss_n_in === 1'b0) begin
			if (armed) got_out = 16'h0000;
			armed = 1'b0;
			if (sclk_in && !sclk_was) got_out = {got_out[14:0], mosi_in};
			if (!sclk_in && sclk_was) idx = idx - 1;
		end
		sclk_was = sclk_in;
	end
	// Released line toggles so a stale bit never passes
	always @(posedge clk_in) junk <= ~junk;
	assign miso_out = (ss_n_in || idx < 0) ? junk : REPLY[idx];
endmodule

// ### testbench/tb_top.sv
// Self-checking bench for the serial master port
// Assumes the slave model on the link and loopback for the later tests
module tb_top
	import ssm_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] REPLY = 16'hB6D1;
	logic core_clk_in = 1'b0;
	logic rst_in = 1'b1;
	ssm_cfg_t cfg = '0;
	logic ovr_clr = 1'b0, rxto_clr = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
	logic [15:0] tx_data = 16'h0000, rx_data, got;
	logic tx_ready, rx_valid, sclk, mosi, miso, ss_n, frame, busy, irq_any;
	ssm_irq_t irq;
	int bad_count = 0, tests_run = 0, cycles = 0, seed = 44;
	int q[$];
	always #5 core_clk_in = ~core_clk_in;
	ssm_port i_ssm_port (.core_clk_in(core_clk_in), .rst_in(rst_in), .cfg_in(cfg), .ovr_clr_in(ovr_clr),
		.rxto_clr_in(rxto_clr), .tx_valid_in(tx_valid), .tx_data_in(tx_data), .tx_ready_out(tx_ready),
		.rx_valid_out(rx_valid), .rx_data_out(rx_data), .rx_ready_in(rx_ready), .sclk_out(sclk),
		.mosi_out(mosi), .miso_in(miso), .ss_n_out(ss_n), .frame_out(frame), .busy_out(busy),
		.irq_out(irq), .irq_any_out(irq_any));
	ssm_slave_model #(.REPLY(REPLY)) i_ssm_slave_model (.clk_in(core_clk_in), .sclk_in(sclk),
		.mosi_in(mosi), .ss_n_in(ss_n), .miso_out(miso), .bits_in(5'(cfg.dss) + 5'h01), .got_out(got));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic close_out();
		$display("counts: run %0d bad %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic push(input logic [15:0] w);
		@(posedge core_clk_in) begin
			tx_valid <= 1'b1;
			tx_data <= w;
		end
		@(posedge core_clk_in) tx_valid <= 1'b0;
	endtask
	task automatic idle();
		int n, run;
		n = 0;
		run = 0;
		while (run < 4 && n < 20000) begin
			@(posedge core_clk_in);
			#1;
			run = (busy === 1'b0) ? run + 1 : 0;
			n++;
		end
		if (n >= 20000) check(16'h0001, 16'h0000);
	endtask
	task automatic pop(input logic [15:0] exp);
		int n;
		n = 0;
		// Let the previous pop settle before looking at the head
		#1;
		while (rx_valid !== 1'b1 && n < 2000) begin
			@(posedge core_clk_in);
			#1;
			n++;
		end
		if (n >= 2000) check(16'h0001, 16'h0000);
		check(rx_data, exp);
		@(posedge core_clk_in) rx_ready <= 1'b1;
		@(posedge core_clk_in) rx_ready <= 1'b0;
	endtask
	function automatic logic [15:0] model_rx(input int f, input logic [3:0] d, input logic [15:0] w);
		if (f == 2)
			return 16'h0000;
		return w & 16'((32'h1 << (int'(d) + 1)) - 1);
	endfunction
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			close_out();
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [15:0] w, v;
		logic [3:0] dss;
		repeat (3) @(posedge core_clk_in);
		rst_in <= 1'b0;
		#1;
		check(16'({ss_n, sclk, frame, busy, tx_ready, rx_valid}), 16'h0022);
		// Mode 0 against the slave model
		@(posedge core_clk_in) cfg <= '{enable: 1'b1, fmt: FMT_SPI, dss: 4'h7, scr: 8'h02, int_mask: 4'hF, default: '0};
		w = 16'($random(seed));
		push(w);
		idle();
		check(got, {8'h00, w[7:0]});
		check(16'({ss_n, frame}), 16'h0002);
		pop({8'h00, REPLY[7:0]});
		$display("test slave frame done");
		// Every format through loopback, size boundaries
		for (int f = 0; f < 3; f++) begin
			for (int d = 0; d < 3; d++) begin
				dss = (d == 0) ? 4'h3 : (d == 1) ? 4'hF : 4'(3 + $unsigned($random(seed)) % 13);
				@(posedge core_clk_in) cfg <= '{enable: 1'b1, fmt: ssm_fmt_t'(f), cpol: 1'($random(seed)),
					cpha: 1'($random(seed)), loopback: 1'b1, dss: dss, presc_sel: 3'(d * 3),
					scr: (d == 2) ? 8'h00 : 8'h02,
					int_mask: 4'hF, default: '0};
				w = 16'($random(seed));
				v = 16'($random(seed));
				push(w);
				push(v);
				idle();
				pop(model_rx(f, dss, w));
				pop(model_rx(f, dss, v));
			end
		end
		$display("test loopback formats done");
		// Fill, watermark, overrun, masking, order
		@(posedge core_clk_in) begin
			cfg.enable <= 1'b0;
			cfg.fmt <= FMT_SPI;
			cfg.dss <= 4'hF;
			cfg.presc_sel <= 3'h0;
			cfg.scr <= 8'h02;
			rxto_clr <= 1'b1;
		end
		@(posedge core_clk_in) rxto_clr <= 1'b0;
		for (int i = 0; i < 9; i++) begin
			w = 16'($random(seed));
			if (i < 8) q.push_back(int'(w));
			push(w);
		end
		#1;
		check(16'(tx_ready), 16'h0000);
		check(16'(irq.tx), 16'h0000);
		@(posedge core_clk_in) cfg.enable <= 1'b1;
		idle();
		check(16'(irq.rx), 16'h0001);
		push(16'h5A5A);
		idle();
		repeat (70) @(posedge core_clk_in);
		#1;
		check(16'(irq), 16'h000F);
		check(16'(irq_any), 16'h0001);
		@(posedge core_clk_in) cfg.int_mask <= 4'h0;
		repeat (3) @(posedge core_clk_in);
		#1;
		check(16'({irq, irq_any}), 16'h0000);
		@(posedge core_clk_in) cfg.int_mask <= 4'hF;
		while (q.size() > 0) pop(16'(q.pop_front()));
		@(posedge core_clk_in) ovr_clr <= 1'b1;
		@(posedge core_clk_in) ovr_clr <= 1'b0;
		repeat (3) @(posedge core_clk_in);
		#1;
		check(16'({irq.ovr, irq.tx}), 16'h0001);
		$display("test fill and flags done");
		close_out();
	end
endmodule
